//--- shared/uvtt_pkg.sv
package uvtt_pkg;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned PROG_CYCLE_NS = 5_000_000;
  localparam int unsigned TICK_CYCLES = PROG_CYCLE_NS / CLK_PERIOD_NS;
  localparam logic [18:0] MAX_TIME_TICKS = 19'h57E40;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_USET = 8'h04;
  localparam logic [7:0] ADDR_UBLK = 8'h08;
  localparam logic [7:0] ADDR_DT_DELAY = 8'h0C;
  localparam logic [7:0] ADDR_TIME_DIAL = 8'h10;
  localparam logic [7:0] ADDR_EXPON = 8'h14;
  localparam logic [7:0] ADDR_RELEASE = 8'h18;
  localparam logic [7:0] ADDR_VT_PRIM = 8'h1C;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_EXP_TIME = 8'h24;
  localparam logic [7:0] ADDR_REMAIN = 8'h28;
  localparam logic [7:0] ADDR_RATIO_A = 8'h2C;
  localparam logic [7:0] ADDR_RATIO_B = 8'h30;
  localparam logic [7:0] ADDR_RATIO_C = 8'h34;
  localparam logic [7:0] ADDR_RATIO_MIN = 8'h38;
  localparam logic [7:0] ADDR_PICK_PRIM = 8'h3C;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h40;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h44;
  // field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_INVERSE_TIME_MODE_BIT = 4;
  localparam int CTRL_DLYREL_BIT = 5;
  localparam int CTRL_RSTAFTER_BIT = 6;
  localparam int CTRL_CONT_BIT = 7;
  localparam int EXPON_FRAC_LSB = 8;
  localparam int STAT_MODE_LSB = 8;
  // stage_operating_mode codes
  localparam logic [2:0] MODE_ON = 3'h0;
  localparam logic [2:0] MODE_BLOCKED = 3'h1;
  localparam logic [2:0] MODE_TEST = 3'h2;
  localparam logic [2:0] MODE_TEST_BLK = 3'h3;
  localparam logic [2:0] MODE_OFF = 3'h4;
  // reset values
  localparam logic [15:0] RST_USET = 16'h1770;
  localparam logic [15:0] RST_UBLK = 16'h03E8;
  localparam logic [18:0] RST_DT_DELAY = 19'h8;
  localparam logic [12:0] RST_TIME_DIAL = 13'h5;
  localparam logic [4:0] RST_EXP_INT = 5'h1;
  localparam logic [6:0] RST_EXP_FRAC = 7'h0;
  localparam logic [18:0] RST_RELEASE = 19'hC;
  localparam logic [19:0] RST_VT_PRIM = 20'h4E20;
  // arithmetic scales
  localparam logic [22:0] PCT_SCALE = 23'h64;
  localparam logic [22:0] HYST_SCALE = 23'h67;
  localparam logic [16:0] Q16_ONE = 17'h10000;
  localparam logic [9:0] FRAC_SCALE = 10'h28F;
  localparam logic [39:0] PRIM_DIV = 40'h3E8;
  localparam int DIV_W = 40;
  localparam int DIV_N = 7;
endpackage : uvtt_pkg

//--- rtl/uvtt_div.sv
module uvtt_div import uvtt_pkg::*; #(
  parameter int W = DIV_W
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic [W-1:0] dividend_in,
  input wire logic [W-1:0] divisor_in,
  output logic [W-1:0] quotient_out,
  output logic done_out
);
  localparam int CW = $clog2(W + 1);

  typedef struct packed {
    logic busy;
    logic done;
    logic [CW-1:0] cnt;
    logic [W-1:0] rem;
    logic [W-1:0] quo;
    logic [W-1:0] dvs;
  } uvtt_div_st_t;

  uvtt_div_st_t s;
  uvtt_div_st_t d;
  logic [W:0] sh;

  // restoring, one quotient bit a cycle; a zero divisor gives all ones
  always_comb begin
    d = s;
    d.done = 1'b0;
    sh = {s.rem, s.quo[W-1]};
    if (start_in) begin
      d.busy = 1'b1;
      d.cnt = CW'(W);
      d.rem = '0;
      d.quo = dividend_in;
      d.dvs = divisor_in;
    end else if (s.busy) begin
      if (sh >= {1'b0, s.dvs}) begin
        d.rem = W'(sh - {1'b0, s.dvs});
        d.quo = {s.quo[W-2:0], 1'b1};
      end else begin
        d.rem = sh[W-1:0];
        d.quo = {s.quo[W-2:0], 1'b0};
      end
      d.cnt = s.cnt - 1'b1;
      if (s.cnt == CW'(1)) begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '0;
    end else begin
      s <= d;
    end
  end

  assign quotient_out = s.quo;
  assign done_out = s.done;
endmodule : uvtt_div

//--- rtl/uvtt_stage.sv
// Function
// - sample block input at each cycle start
// - pick-up without block raises start, timing
// - pick-up with block: blocked, no timing
// - block after start clears start, resets timing
// - instant mode trips with start
// - fixed delay trips after continuous pick-up
// - inverse delay is k over 1-ratio^a
// - expected time at 5 ms, follows voltage
// - remaining time to trip at 5 ms
// - per-channel and lowest ratios at 0.01
// - below block level inhibits trip until recovery
// - primary pick-up voltage at 0.1 V
// - report one of five operating modes
// - release at 103 percent of pick-up
// - zero fixed delay means instant operation
// - delayed release holds start for release time
module uvtt_stage import uvtt_pkg::*; #(
  parameter int unsigned TICK_CYC = TICK_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic [15:0] meas_a_in,
  input wire logic [15:0] meas_b_in,
  input wire logic [15:0] meas_c_in,
  input wire logic ext_block_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  output logic start_out,
  output logic trip_out,
  output logic blocked_out,
  output logic irq_out
);
  typedef enum logic [1:0] {PH_IDLE, PH_RATIO, PH_POWER, PH_TIME} uvtt_phase_t;

  typedef struct packed {
    logic [31:0] tick_cnt;
    logic tick;
    logic [2:0] mode;
    logic inverse_time_mode;
    logic dly_rel;
    logic rst_after;
    logic cont_calc;
    logic [15:0] uset;
    logic [15:0] ublk;
    logic [18:0] dt_delay;
    logic [12:0] k;
    logic [4:0] a_int;
    logic [6:0] a_frac;
    logic [18:0] rel_time;
    logic [19:0] vt_prim;
    logic blk;
    logic pk;
    logic uvb;
    logic start;
    logic trip;
    logic trip_pin;
    logic blocked;
    logic [18:0] op_cnt;
    logic [18:0] rel_cnt;
    logic [18:0] exp_time;
    logic [18:0] inverse_time_mode_t;
    logic [19:0] remain;
    logic [3:0][16:0] ratio;
    logic [23:0] pick_prim;
    uvtt_phase_t phase;
    logic [4:0] pw_cnt;
    logic [16:0] rq;
    logic [16:0] pw;
    logic [16:0] denom;
    logic inverse_time_mode_go;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic irq;
    logic [31:0] rdata;
  } uvtt_st_t;

  uvtt_st_t s;
  uvtt_st_t d;
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [2:0][15:0] meas;
  logic [15:0] vmin;
  logic all_up;
  logic all_above;
  logic blk_src;
  logic [3:0] set_ev;
  logic [3:0] clr_ev;
  logic [33:0] prod;
  logic [33:0] t1;
  logic [33:0] t2;
  logic [16:0] frac_mul;
  logic [DIV_N-1:0] div_start;
  logic [DIV_N-1:0] div_done;
  logic [DIV_N-1:0][DIV_W-1:0] div_n;
  logic [DIV_N-1:0][DIV_W-1:0] div_d;
  logic [DIV_N-1:0][DIV_W-1:0] div_q;

  function automatic logic above_hyst(input logic [15:0] v, input logic [15:0] u);
    return (23'(v) * PCT_SCALE) >= (23'(u) * HYST_SCALE);
  endfunction : above_hyst

  function automatic logic [18:0] sat_inc(input logic [18:0] v);
    return (v == MAX_TIME_TICKS) ? v : v + 19'h1;
  endfunction : sat_inc

  function automatic logic [18:0] clamp_time(input logic [DIV_W-1:0] q);
    return (q > DIV_W'(MAX_TIME_TICKS)) ? MAX_TIME_TICKS : q[18:0];
  endfunction : clamp_time

  // reset enters asynchronously, is released on the clock
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  assign meas = {meas_c_in, meas_b_in, meas_a_in};
  assign vmin = (meas_a_in < meas_b_in) ?
                ((meas_a_in < meas_c_in) ? meas_a_in : meas_c_in) :
                ((meas_b_in < meas_c_in) ? meas_b_in : meas_c_in);
  assign all_up = above_hyst(meas_a_in, s.uset) && above_hyst(meas_b_in, s.uset) &&
                  above_hyst(meas_c_in, s.uset);
  assign all_above = (meas_a_in > s.uset) && (meas_b_in > s.uset) && (meas_c_in > s.uset);
  assign blk_src = ext_block_in || (s.mode == MODE_BLOCKED) || (s.mode == MODE_TEST_BLK);

  // ratio dividers run from the same cycle start as the pick-up decision
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ch
      assign div_n[g] = DIV_W'(meas[g]) * DIV_W'(PCT_SCALE);
      assign div_d[g] = DIV_W'(s.uset);
    end
    for (g = 0; g < DIV_N; g++) begin : g_div
      assign div_start[g] = (g == 5) ? s.inverse_time_mode_go : s.tick;
      uvtt_div #(.W(DIV_W)) u_div (
        .clk_in(sys_clk_in),
        .rst_n_in(rst_n),
        .start_in(div_start[g]),
        .dividend_in(div_n[g]),
        .divisor_in(div_d[g]),
        .quotient_out(div_q[g]),
        .done_out(div_done[g])
      );
    end
  endgenerate
  assign div_n[3] = DIV_W'(vmin) * DIV_W'(PCT_SCALE);
  assign div_d[3] = DIV_W'(s.uset);
  assign div_n[4] = DIV_W'(vmin) << 16;
  assign div_d[4] = DIV_W'(s.uset);
  assign div_n[5] = DIV_W'(s.k) << 17;
  assign div_d[5] = DIV_W'(s.denom);
  assign div_n[6] = DIV_W'(s.uset) * DIV_W'(s.vt_prim);
  assign div_d[6] = PRIM_DIV;

  // fractional exponent is a first-order step, exact at whole exponents
  assign prod = 34'(s.pw) * 34'(s.rq);
  assign t1 = 34'(s.pw) * 34'(Q16_ONE - s.rq);
  assign frac_mul = 17'(s.a_frac) * 17'(FRAC_SCALE);
  assign t2 = 34'(t1[32:16]) * 34'(frac_mul);

  always_comb begin
    d = s;
    d.tick = 1'b0;
    d.inverse_time_mode_go = 1'b0;
    d.rdata = '0;
    set_ev = '0;
    clr_ev = '0;
    if (s.tick_cnt == 32'(TICK_CYC - 1)) begin
      d.tick_cnt = '0;
      d.tick = 1'b1;
    end else begin
      d.tick_cnt = s.tick_cnt + 32'h1;
    end
    if (s.tick) begin
      d.blk = blk_src;
      if (s.mode == MODE_OFF || s.uset == 16'h0) begin
        d.pk = 1'b0;
      end else if (s.pk) begin
        d.pk = !all_up;
      end else begin
        d.pk = vmin < s.uset;
      end
      if (s.ublk == 16'h0) begin
        d.uvb = 1'b0;
      end else if (vmin < s.ublk) begin
        d.uvb = 1'b1;
      end else if (all_above) begin
        d.uvb = 1'b0;
      end
      if (d.pk && !d.blk) begin
        d.start = 1'b1;
        d.blocked = 1'b0;
        d.rel_cnt = '0;
        d.op_cnt = sat_inc(s.op_cnt);
        d.trip = !d.uvb && (s.op_cnt >= s.exp_time);
      end else if (d.blk) begin
        d.blocked = d.pk;
        d.start = 1'b0;
        d.trip = 1'b0;
        d.op_cnt = '0;
        d.rel_cnt = '0;
      end else begin
        d.blocked = 1'b0;
        d.trip = 1'b0;
        if (s.start && s.dly_rel && s.rel_cnt < s.rel_time) begin
          d.rel_cnt = sat_inc(s.rel_cnt);
          if (s.cont_calc) begin
            d.op_cnt = sat_inc(s.op_cnt);
          end else if (!s.rst_after) begin
            d.op_cnt = '0;
          end
        end else begin
          d.start = 1'b0;
          d.op_cnt = '0;
          d.rel_cnt = '0;
        end
      end
      // test modes show the trip but keep it off the output
      d.trip_pin = d.trip && s.mode != MODE_TEST && s.mode != MODE_TEST_BLK;
      d.remain = d.start ? 20'({1'b0, s.exp_time} - {1'b0, d.op_cnt}) : 20'h0;
      set_ev = {d.uvb && !s.uvb, d.blocked && !s.blocked, d.trip && !s.trip,
                d.start && !s.start};
    end
    d.exp_time = s.inverse_time_mode ? s.inverse_time_mode_t : s.dt_delay;
    for (int i = 0; i < 4; i++) begin
      if (div_done[i]) begin
        d.ratio[i] = (div_q[i] > DIV_W'(17'h1FFFF)) ? 17'h1FFFF : div_q[i][16:0];
      end
    end
    if (div_done[6]) begin
      d.pick_prim = (div_q[6] > DIV_W'(24'hFFFFFF)) ? 24'hFFFFFF : div_q[6][23:0];
    end
    // inverse time: ratio, then power, then k over (1 - power)
    case (s.phase)
      PH_IDLE: begin
        if (s.tick) begin
          d.phase = PH_RATIO;
        end
      end
      PH_RATIO: begin
        if (div_done[4]) begin
          d.rq = (div_q[4] > DIV_W'(Q16_ONE)) ? Q16_ONE : div_q[4][16:0];
          d.pw = Q16_ONE;
          d.pw_cnt = s.a_int;
          d.phase = PH_POWER;
        end
      end
      PH_POWER: begin
        if (s.pw_cnt != 5'h0) begin
          d.pw = prod[32:16];
          d.pw_cnt = s.pw_cnt - 5'h1;
        end else begin
          d.denom = Q16_ONE - (s.pw - t2[32:16]);
          d.inverse_time_mode_go = 1'b1;
          d.phase = PH_TIME;
        end
      end
      PH_TIME: begin
        if (div_done[5]) begin
          d.inverse_time_mode_t = clamp_time(div_q[5]);
          d.phase = PH_IDLE;
        end
      end
      default: d.phase = PH_IDLE;
    endcase
    if (wr_in) begin
      case (addr_in)
        ADDR_CTRL: begin
          if (wdata_in[CTRL_MODE_LSB +: 3] <= MODE_OFF) begin
            d.mode = wdata_in[CTRL_MODE_LSB +: 3];
          end
          d.inverse_time_mode = wdata_in[CTRL_INVERSE_TIME_MODE_BIT];
          d.dly_rel = wdata_in[CTRL_DLYREL_BIT];
          d.rst_after = wdata_in[CTRL_RSTAFTER_BIT];
          d.cont_calc = wdata_in[CTRL_CONT_BIT];
        end
        ADDR_USET: d.uset = wdata_in[15:0];
        ADDR_UBLK: d.ublk = wdata_in[15:0];
        ADDR_DT_DELAY: d.dt_delay = wdata_in[18:0];
        ADDR_TIME_DIAL: d.k = wdata_in[12:0];
        ADDR_EXPON: begin
          d.a_int = wdata_in[4:0];
          d.a_frac = wdata_in[EXPON_FRAC_LSB +: 7];
        end
        ADDR_RELEASE: d.rel_time = wdata_in[18:0];
        ADDR_VT_PRIM: d.vt_prim = wdata_in[19:0];
        ADDR_IRQ_STAT: clr_ev = wdata_in[3:0];
        ADDR_IRQ_MASK: d.irq_mask = wdata_in[3:0];
        default: ;
      endcase
    end
    // a new event beats a clear in the same cycle
    d.irq_stat = (s.irq_stat & ~clr_ev) | set_ev;
    d.irq = |(d.irq_stat & d.irq_mask);
    if (rd_in) begin
      case (addr_in)
        ADDR_CTRL: d.rdata = 32'({s.cont_calc, s.rst_after, s.dly_rel, s.inverse_time_mode, 1'b0, s.mode});
        ADDR_USET: d.rdata = 32'(s.uset);
        ADDR_UBLK: d.rdata = 32'(s.ublk);
        ADDR_DT_DELAY: d.rdata = 32'(s.dt_delay);
        ADDR_TIME_DIAL: d.rdata = 32'(s.k);
        ADDR_EXPON: d.rdata = 32'({1'b0, s.a_frac, 3'h0, s.a_int});
        ADDR_RELEASE: d.rdata = 32'(s.rel_time);
        ADDR_VT_PRIM: d.rdata = 32'(s.vt_prim);
        ADDR_STATUS: d.rdata = 32'({s.mode, 3'h0, s.pk, s.uvb, s.blocked, s.trip, s.start});
        ADDR_EXP_TIME: d.rdata = 32'(s.exp_time);
        ADDR_REMAIN: d.rdata = 32'(s.remain);
        ADDR_RATIO_A: d.rdata = 32'(s.ratio[0]);
        ADDR_RATIO_B: d.rdata = 32'(s.ratio[1]);
        ADDR_RATIO_C: d.rdata = 32'(s.ratio[2]);
        ADDR_RATIO_MIN: d.rdata = 32'(s.ratio[3]);
        ADDR_PICK_PRIM: d.rdata = 32'(s.pick_prim);
        ADDR_IRQ_STAT: d.rdata = 32'(s.irq_stat);
        ADDR_IRQ_MASK: d.rdata = 32'(s.irq_mask);
        default: d.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.mode <= MODE_ON;
      s.dly_rel <= 1'b1;
      s.rst_after <= 1'b1;
      s.uset <= RST_USET;
      s.ublk <= RST_UBLK;
      s.dt_delay <= RST_DT_DELAY;
      s.k <= RST_TIME_DIAL;
      s.a_int <= RST_EXP_INT;
      s.a_frac <= RST_EXP_FRAC;
      s.rel_time <= RST_RELEASE;
      s.vt_prim <= RST_VT_PRIM;
      s.phase <= PH_IDLE;
    end else begin
      s <= d;
    end
  end

  assign rdata_out = s.rdata;
  assign start_out = s.start;
  assign trip_out = s.trip_pin;
  assign blocked_out = s.blocked;
  assign irq_out = s.irq;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n);

  blk_sample_a: assert property (s.tick |=> s.blk == $past(blk_src))
    else $error("block input not taken at cycle start");
  start_cause_a: assert property ($rose(s.start) |-> s.pk && !s.blk)
    else $error("start rose without clean pick-up");
  blocked_quiet_a: assert property (s.blocked |-> !s.start && !s.trip)
    else $error("blocked stage still timing");
  block_clears_a: assert property (s.tick && blk_src |=> !s.start && !s.trip)
    else $error("block did not clear start");
  instant_trip_a: assert property ($rose(s.start) && $past(s.exp_time) == 19'h0
      && !s.uvb |-> s.trip)
    else $error("instant stage did not trip with start");
  delay_trip_a: assert property ($rose(s.trip) |-> $past(s.op_cnt) >= $past(s.exp_time))
    else $error("trip before delay elapsed");
  trip_gate_a: assert property (s.trip |-> s.pk && !s.blk && !s.uvb)
    else $error("trip without live pick-up");
  remain_idle_a: assert property (!s.start |-> s.remain == 20'h0)
    else $error("remaining time shown while idle");
  hyst_hold_a: assert property (s.tick && s.pk && !all_up && s.mode != MODE_OFF
      && s.uset != 16'h0 |=> s.pk)
    else $error("pick-up released inside hysteresis");
  mode_range_a: assert property (s.mode <= MODE_OFF)
    else $error("operating mode out of range");
endmodule : uvtt_stage

//--- dv/uvtt_front.sv
module uvtt_front (
  input wire logic sys_clk_in,
  input wire logic [15:0] volt_a_in,
  input wire logic [15:0] volt_b_in,
  input wire logic [15:0] volt_c_in,
  input wire logic block_req_in,
  output logic [15:0] meas_a_out = 16'h2710,
  output logic [15:0] meas_b_out = 16'h2710,
  output logic [15:0] meas_c_out = 16'h2710,
  output logic ext_block_out = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // front end updates just after every rising clock edge and holds until the next one
  always @(posedge sys_clk_in) begin
    meas_a_out <= volt_a_in;
    meas_b_out <= volt_b_in;
    meas_c_out <= volt_c_in;
    // block follows the request one clock cycle later
    ext_block_out <= block_req_in;
  end
endmodule : uvtt_front

//--- dv/uvtt_stage_tb.sv
module uvtt_stage_tb import uvtt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned TC = 200;
  localparam int MIDP = 106;
  logic sys_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [15:0] va = 16'h2710;
  logic [15:0] vb = 16'h2710;
  logic [15:0] vc = 16'h2710;
  logic blk_req = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [15:0] meas_a, meas_b, meas_c;
  logic ext_block;
  logic [31:0] rdata_out;
  logic start_out, trip_out, blocked_out, irq_out;
  int bad_count = 0;
  int cmp_count = 0;
  int ph = 0;
  always #50 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) ph <= ph + 1;
  uvtt_front uvtt_front_inst (.sys_clk_in(sys_clk_in), .volt_a_in(va), .volt_b_in(vb),
    .volt_c_in(vc), .block_req_in(blk_req), .meas_a_out(meas_a), .meas_b_out(meas_b),
    .meas_c_out(meas_c), .ext_block_out(ext_block));
  uvtt_stage #(.TICK_CYC(TC)) uvtt_stage_inst (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
    .meas_a_in(meas_a), .meas_b_in(meas_b), .meas_c_in(meas_c), .ext_block_in(ext_block),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .start_out(start_out), .trip_out(trip_out),
    .blocked_out(blocked_out), .irq_out(irq_out));
  function automatic logic [31:0] ratio_of(input logic [15:0] v, input logic [15:0] us);
    return (32'(v) * 32'h64) / 32'(us);
  endfunction : ratio_of
  // linear in r only while the exponent is a whole 1
  function automatic logic [31:0] inverse_time_mode_of(input int k, input logic [15:0] m, input logic [15:0] us);
    return (2 * k * 65536) / (65536 - (int'(m) * 65536) / int'(us));
  endfunction : inverse_time_mode_of
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    @(negedge sys_clk_in);
    d = rdata_out;
  endtask : rd
  task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(what, exp, d);
  endtask : rc
  // sample half a program cycle away from the tick so outputs are settled
  task automatic mid(input int n);
    repeat (n) begin
      @(negedge sys_clk_in);
      while (ph % TC != MIDP) @(negedge sys_clk_in);
    end
  endtask : mid
  task automatic flags(input logic [2:0] e);
    chk("start_trip_blocked", {29'h0, e}, {29'h0, start_out, trip_out, blocked_out});
  endtask : flags
  task automatic setv(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    @(posedge sys_clk_in);
    va <= a;
    vb <= b;
    vc <= c;
  endtask : setv
  task automatic setb(input logic b);
    @(posedge sys_clk_in);
    blk_req <= b;
  endtask : setb
  task automatic healthy;
    setv(16'h2710, 16'h2710, 16'h2710);
    mid(1);
  endtask : healthy
  initial begin
    repeat (100000) @(posedge sys_clk_in);
    bad_count++;
    wrap_up();
  end
  initial begin
    logic [15:0] v;
    logic [31:0] d;
    logic [2:0] mexp [5];
    logic [7:0] r [3];
    int k;
    mexp = '{3'b110, 3'b001, 3'b100, 3'b001, 3'b000};
    k = $urandom(67);
    repeat (4) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    rc("uset", ADDR_USET, 32'(RST_USET));
    rc("dt_delay", ADDR_DT_DELAY, 32'(RST_DT_DELAY));
    rc("release", ADDR_RELEASE, 32'(RST_RELEASE));
    rc("unmapped", 8'hFC, 32'h0);
    // first tick comes a whole program cycle after reset: park before it
    mid(1);
    $display("test reset done");
    wr(ADDR_CTRL, 32'h40);
    wr(ADDR_DT_DELAY, 32'h3);
    wr(ADDR_IRQ_MASK, 32'h1);
    v = 16'h03E9 + 16'($urandom % 32'h1387);
    setv(16'h2710, v, 16'h2710);
    mid(1);
    flags(3'b100);
    rc("exp_time", ADDR_EXP_TIME, 32'h3);
    rc("remain", ADDR_REMAIN, 32'h2);
    chk("irq", 32'h1, {31'h0, irq_out});
    mid(2);
    flags(3'b100);
    mid(1);
    flags(3'b110);
    setv(16'h2710, 16'h1823, 16'h2710);
    mid(1);
    flags(3'b110);
    setv(16'h2710, 16'h1824, 16'h2710);
    mid(1);
    flags(3'b000);
    rc("irq_stat", ADDR_IRQ_STAT, 32'h3);
    wr(ADDR_IRQ_STAT, 32'h1);
    rc("irq_stat", ADDR_IRQ_STAT, 32'h2);
    chk("irq", 32'h0, {31'h0, irq_out});
    setv(16'h2710, 16'h2710, v);
    mid(1);
    flags(3'b100);
    mid(3);
    flags(3'b110);
    healthy();
    $display("test fixed delay done");
    setb(1'b1);
    setv(v, 16'h2710, 16'h2710);
    mid(1);
    flags(3'b001);
    mid(4);
    flags(3'b001);
    setb(1'b0);
    mid(2);
    flags(3'b100);
    setb(1'b1);
    mid(1);
    flags(3'b001);
    setb(1'b0);
    mid(1);
    flags(3'b100);
    mid(3);
    flags(3'b110);
    healthy();
    $display("test block done");
    wr(ADDR_DT_DELAY, 32'h0);
    setv(16'h2710, 16'h2710, v);
    mid(1);
    flags(3'b110);
    wr(ADDR_CTRL, 32'h60);
    wr(ADDR_RELEASE, 32'h3);
    healthy();
    flags(3'b100);
    mid(4);
    flags(3'b000);
    // timer keeps running through release, so a quick return trips early
    wr(ADDR_CTRL, 32'hA0);
    wr(ADDR_DT_DELAY, 32'h3);
    setv(v, 16'h2710, 16'h2710);
    mid(1);
    flags(3'b100);
    healthy();
    flags(3'b100);
    setv(v, 16'h2710, 16'h2710);
    mid(1);
    flags(3'b100);
    mid(1);
    flags(3'b110);
    wr(ADDR_DT_DELAY, 32'h0);
    healthy();
    wr(ADDR_CTRL, 32'h40);
    $display("test instant and release done");
    setv(16'h01F4, 16'h01F4, 16'h01F4);
    mid(1);
    flags(3'b100);
    rd(ADDR_STATUS, d);
    chk("uv_flag", 32'h8, d & 32'h8);
    setv(16'h0BB8, 16'h0BB8, 16'h0BB8);
    mid(1);
    flags(3'b100);
    setv(16'h1B58, 16'h1B58, 16'h1B58);
    mid(1);
    setv(16'h0BB8, 16'h0BB8, 16'h0BB8);
    mid(1);
    flags(3'b110);
    $display("test undervoltage block done");
    for (int m = 0; m < 5; m++) begin
      wr(ADDR_CTRL, 32'h40 | 32'(m));
      mid(1);
      rd(ADDR_STATUS, d);
      chk("mode", 32'(m), (d >> STAT_MODE_LSB) & 32'h7);
      flags(mexp[m]);
    end
    wr(ADDR_CTRL, 32'h45);
    rd(ADDR_STATUS, d);
    chk("mode", 32'(MODE_OFF), (d >> STAT_MODE_LSB) & 32'h7);
    wr(ADDR_CTRL, 32'h40);
    healthy();
    $display("test modes done");
    wr(ADDR_USET, 32'h1388);
    wr(ADDR_VT_PRIM, 32'h4E20);
    for (int i = 0; i < 3; i++) r[i] = 8'h82 + 8'($urandom % 32'h6F);
    setv(16'h32 * r[0], 16'h32 * r[1], 16'h32 * r[2]);
    mid(2);
    rc("ratio_a", ADDR_RATIO_A, ratio_of(16'h32 * r[0], 16'h1388));
    rc("ratio_b", ADDR_RATIO_B, ratio_of(16'h32 * r[1], 16'h1388));
    rc("ratio_c", ADDR_RATIO_C, ratio_of(16'h32 * r[2], 16'h1388));
    v = 16'h32 * ((r[0] < r[1]) ? ((r[0] < r[2]) ? r[0] : r[2]) : ((r[1] < r[2]) ? r[1] : r[2]));
    rc("ratio_min", ADDR_RATIO_MIN, ratio_of(v, 16'h1388));
    rc("pick_prim", ADDR_PICK_PRIM, 32'h186A0);
    $display("test ratios done");
    wr(ADDR_CTRL, 32'h50);
    wr(ADDR_TIME_DIAL, 32'h2);
    wr(ADDR_EXPON, 32'h1);
    setv(16'h09C4, 16'h2710, 16'h2710);
    mid(2);
    rc("exp_time", ADDR_EXP_TIME, inverse_time_mode_of(2, 16'h09C4, 16'h1388));
    setv(16'h0EA6, 16'h2710, 16'h2710);
    mid(2);
    rc("exp_time", ADDR_EXP_TIME, inverse_time_mode_of(2, 16'h0EA6, 16'h1388));
    healthy();
    $display("test inverse time done");
    wrap_up();
  end
endmodule : uvtt_stage_tb
